// ==== hdl/pfr_pkg.sv ====
// Purpose: shared constants and types for the packet feature and retransmit controller
// Assumes: registers reached by a simple internal register port at their printed offsets
// Notes: timing counts derive from a 100 MHz clock
package pfr_pkg;
  // register offsets as printed
  localparam logic [7:0] DYN_LEN_OFFSET = 8'h1c;
  localparam logic [7:0] FEATURE_OFFSET = 8'h1d;
  // feature register field positions
  localparam int FEAT_DYN_LEN_BIT = 2;
  localparam int FEAT_ACK_PAY_BIT = 1;
  localparam int FEAT_NOACK_BIT = 0;
  // writable masks; reserved bits always read zero
  localparam logic [7:0] FEATURE_MASK = 8'h07;
  localparam logic [7:0] DYN_LEN_MASK = 8'h3f;
  // reset values
  localparam logic [7:0] FEATURE_RESET = 8'h00;
  localparam logic [7:0] DYN_LEN_RESET = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_WAIT_US = 250;
  localparam int ADDR_WAIT_SLOW_US = 500;
  localparam int ADDR_WAIT_CYC = ADDR_WAIT_US * 1000 / CLK_PERIOD_NS;
  localparam int ADDR_WAIT_SLOW_CYC = ADDR_WAIT_SLOW_US * 1000 / CLK_PERIOD_NS;
  // retransmit delay step: 250 us per code step, code 0 means 250 us
  localparam int RTX_STEP_US = 250;
  localparam int RTX_STEP_CYC = RTX_STEP_US * 1000 / CLK_PERIOD_NS;
  // pending acknowledgement payload depth
  localparam int ACK_PAY_DEPTH = 3;
  // air rate codes
  typedef enum logic [1:0] {
    PFR_RATE_1M = 2'b00,
    PFR_RATE_2M = 2'b01,
    PFR_RATE_250K = 2'b10
  } pfr_rate_e;
  // transmitter wait states
  typedef enum logic [2:0] {
    PFR_IDLE = 3'b000,
    PFR_TX = 3'b001,
    PFR_LISTEN = 3'b010,
    PFR_RECV = 3'b011,
    PFR_STBY2 = 3'b100
  } pfr_state_e;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pfr_reg_req_s;
  // acknowledgement payload entry
  typedef struct packed {
    logic [2:0] pipe;
    logic [5:0] len;
  } pfr_ack_pay_s;
endpackage

// ==== hdl/pfr_ctrl.sv ====
// Purpose: packet feature controls, ack payload queue, retransmit wait timing, rx ready flag
// Assumes: same-clock inputs from the command decoder and radio core; no pin inputs
// Notes: air timing counts run on the 100 MHz system clock
module pfr_ctrl #(
  parameter int PIPES = 6,
  parameter int ADDR_WAIT_CYCLES = pfr_pkg::ADDR_WAIT_CYC,
  parameter int ADDR_WAIT_SLOW_CYCLES = pfr_pkg::ADDR_WAIT_SLOW_CYC,
  parameter int RTX_STEP_CYCLES = pfr_pkg::RTX_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire pfr_pkg::pfr_reg_req_s reg_req, // register access, one cycle strobes
  output logic [7:0] reg_rdata, // read data, valid the cycle after rd
  input wire logic [5:0] auto_ack_pipe_enable, // per-pipe auto-ack enables
  input wire logic [3:0] retransmit_delay, // delay code, step 250 us
  input wire pfr_pkg::pfr_rate_e air_rate, // current air rate
  input wire logic noack_cmd_req, // command decoder saw the no-ack write
  output logic write_tx_payload_without_ack, // accepted no-ack command pulse
  input wire logic ack_pay_push, // host queues an ack payload
  input wire pfr_pkg::pfr_ack_pay_s ack_pay_in, // its pipe and length
  output logic ack_pay_full, // queue holds three
  input wire logic ack_pay_pop, // radio sent an ack for ack_pay_pipe
  input wire logic [2:0] ack_pay_pipe, // pipe being acknowledged
  output logic ack_pay_hit, // a payload is pending for that pipe
  output pfr_pkg::pfr_ack_pay_s ack_pay_out, // oldest payload for that pipe
  output logic ack_dyn_len, // acknowledgements use variable length
  output logic [5:0] pipe_dyn_len, // effective per-pipe dynamic length
  input wire logic tx_start, // start of a transmitted packet
  input wire logic tx_done, // packet left the air
  input wire logic addr_match, // address matched while listening
  input wire logic rx_pkt_end, // received packet ended
  input wire logic ack_ok, // a valid acknowledgement arrived
  output pfr_pkg::pfr_state_e tx_state, // transmitter wait state
  output logic resend, // pulse: resend the same packet
  input wire logic new_packet, // a new packet reached the rx fifo
  input wire logic rx_ready_clear, // host writes one to clear
  output logic receive_data_ready_flag // sticky rx ready flag
);
  // register storage
  logic [7:0] feature_control_q;
  logic [7:0] dynamic_length_pipe_enables_q;
  logic [7:0] rdata_q;
  // feature fields
  logic global_dynamic_length_enable;
  logic ack_payload_enable;
  logic selective_noack_enable;
  // pending ack payload storage
  pfr_pkg::pfr_ack_pay_s ack_mem_q [pfr_pkg::ACK_PAY_DEPTH];
  logic [pfr_pkg::ACK_PAY_DEPTH-1:0] ack_vld_q;
  logic [1:0] hit_idx;
  // wait timing
  pfr_pkg::pfr_state_e state_q;
  // a four-bit delay code gives at most sixteen steps; size the delay counter from that
  // so the longest delay cannot wrap at the default step length
  localparam int RTX_W = $clog2(16 * RTX_STEP_CYCLES + 1);
  logic [RTX_W-1:0] rtx_cnt_q; // cycles since the packet left the air
  logic [16:0] lst_cnt_q;
  logic [RTX_W-1:0] rtx_limit; // delay length in cycles
  logic [16:0] lst_limit;
  logic [16:0] listen_age_q; // checker helper: cycles spent listening
  logic rtx_expired;
  logic lst_expired;
  logic resend_q;
  logic rdy_q;

  assign global_dynamic_length_enable = feature_control_q[pfr_pkg::FEAT_DYN_LEN_BIT];
  assign ack_payload_enable = feature_control_q[pfr_pkg::FEAT_ACK_PAY_BIT];
  assign selective_noack_enable = feature_control_q[pfr_pkg::FEAT_NOACK_BIT];

  // register writes; reserved bits are masked so they never store
  always_ff @(posedge clk) begin
    if (rst) begin
      feature_control_q <= pfr_pkg::FEATURE_RESET;
      dynamic_length_pipe_enables_q <= pfr_pkg::DYN_LEN_RESET;
    end else if (reg_req.wr) begin
      if (reg_req.addr == pfr_pkg::FEATURE_OFFSET) begin
        feature_control_q <= reg_req.wdata & pfr_pkg::FEATURE_MASK;
      end else if (reg_req.addr == pfr_pkg::DYN_LEN_OFFSET) begin
        dynamic_length_pipe_enables_q <= reg_req.wdata & pfr_pkg::DYN_LEN_MASK;
      end
    end
  end

  // register reads; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_req.rd) begin
      if (reg_req.addr == pfr_pkg::FEATURE_OFFSET) begin
        rdata_q <= feature_control_q;
      end else if (reg_req.addr == pfr_pkg::DYN_LEN_OFFSET) begin
        rdata_q <= dynamic_length_pipe_enables_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end
  assign reg_rdata = rdata_q;

  // effective dynamic length per pipe needs both global and auto-ack enables
  for (genvar p = 0; p < PIPES; p++) begin : g_pipe
    assign pipe_dyn_len[p] = dynamic_length_pipe_enables_q[p] & global_dynamic_length_enable
                             & auto_ack_pipe_enable[p];
  end

  // ack payloads always go out with variable length
  assign ack_dyn_len = ack_payload_enable;

  // no-ack command passes only when the feature bit allows it
  assign write_tx_payload_without_ack = noack_cmd_req & selective_noack_enable;

  // find the oldest pending entry for the pipe being acknowledged; slot 0 is oldest
  always_comb begin
    hit_idx = 2'd0;
    ack_pay_hit = 1'b0;
    for (int i = pfr_pkg::ACK_PAY_DEPTH - 1; i >= 0; i--) begin
      if (ack_vld_q[i] && ack_mem_q[i].pipe == ack_pay_pipe) begin
        hit_idx = 2'(i);
        ack_pay_hit = 1'b1;
      end
    end
  end
  assign ack_pay_out = ack_mem_q[hit_idx];
  assign ack_pay_full = &ack_vld_q;

  // ack payload queue kept in arrival order; pop compacts, push fills the first hole
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_vld_q <= '0;
      for (int i = 0; i < pfr_pkg::ACK_PAY_DEPTH; i++) begin
        ack_mem_q[i] <= '0;
      end
    end else begin
      logic [pfr_pkg::ACK_PAY_DEPTH-1:0] v;
      pfr_pkg::pfr_ack_pay_s m [pfr_pkg::ACK_PAY_DEPTH];
      int fill; // lowest free slot after any pop
      v = ack_vld_q;
      m = ack_mem_q;
      fill = 0;
      if (ack_pay_pop && ack_pay_hit && ack_payload_enable) begin
        for (int i = 0; i < pfr_pkg::ACK_PAY_DEPTH - 1; i++) begin
          if (i >= int'(hit_idx)) begin
            m[i] = m[i+1];
            v[i] = v[i+1];
          end
        end
        v[pfr_pkg::ACK_PAY_DEPTH-1] = 1'b0;
      end
      // a push while full is dropped unless a pop frees a slot in the same cycle; the host must watch ack_pay_full
      if (ack_pay_push && !(&v)) begin
        // the queue stays compacted, so the lowest free slot is the tail
        for (int i = pfr_pkg::ACK_PAY_DEPTH - 1; i >= 0; i--) begin
          if (!v[i]) begin
            fill = i;
          end
        end
        m[fill] = ack_pay_in;
        v[fill] = 1'b1;
      end
      ack_vld_q <= v;
      ack_mem_q <= m;
    end
  end

  // limits: delay runs (code+1) steps; listen window doubles at 250 kbps
  assign rtx_limit = RTX_W'((int'(retransmit_delay) + 1) * RTX_STEP_CYCLES);
  assign lst_limit = (air_rate == pfr_pkg::PFR_RATE_250K) ? 17'(ADDR_WAIT_SLOW_CYCLES)
                                                          : 17'(ADDR_WAIT_CYCLES);
  assign rtx_expired = rtx_cnt_q >= rtx_limit - RTX_W'(1);
  assign lst_expired = lst_cnt_q >= lst_limit - 17'd1;

  // retransmit delay counter starts when the packet leaves the air
  always_ff @(posedge clk) begin
    if (rst || state_q == pfr_pkg::PFR_IDLE || state_q == pfr_pkg::PFR_TX) begin
      rtx_cnt_q <= '0;
    end else if (!rtx_expired) begin
      rtx_cnt_q <= rtx_cnt_q + RTX_W'(1);
    end
  end

  // listen window counter runs only while waiting for an address
  always_ff @(posedge clk) begin
    if (rst || state_q != pfr_pkg::PFR_LISTEN) begin
      lst_cnt_q <= '0;
    end else if (!lst_expired) begin
      lst_cnt_q <= lst_cnt_q + 17'd1;
    end
  end

  // transmitter wait sequence; an acknowledgement ends the wait without resend unless the delay expires in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= pfr_pkg::PFR_IDLE;
      resend_q <= 1'b0;
    end else begin
      resend_q <= 1'b0;
      case (state_q)
        pfr_pkg::PFR_IDLE: begin
          if (tx_start) state_q <= pfr_pkg::PFR_TX;
        end
        pfr_pkg::PFR_TX: begin
          if (tx_done) state_q <= pfr_pkg::PFR_LISTEN;
        end
        pfr_pkg::PFR_LISTEN: begin
          if (rtx_expired) begin
            state_q <= pfr_pkg::PFR_TX;
            resend_q <= 1'b1;
          end else if (addr_match) begin
            state_q <= pfr_pkg::PFR_RECV;
          end else if (lst_expired) begin
            state_q <= pfr_pkg::PFR_STBY2;
          end
        end
        pfr_pkg::PFR_RECV: begin
          if (rtx_expired) begin
            state_q <= pfr_pkg::PFR_TX;
            resend_q <= 1'b1;
          end else if (rx_pkt_end && ack_ok) begin
            state_q <= pfr_pkg::PFR_IDLE;
          end else if (rx_pkt_end) begin
            state_q <= pfr_pkg::PFR_STBY2;
          end
        end
        pfr_pkg::PFR_STBY2: begin
          if (rtx_expired) begin
            state_q <= pfr_pkg::PFR_TX;
            resend_q <= 1'b1;
          end
        end
        default: state_q <= pfr_pkg::PFR_IDLE;
      endcase
    end
  end
  assign tx_state = state_q;
  assign resend = resend_q;

  // sticky ready flag; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      rdy_q <= 1'b0;
    end else if (new_packet) begin
      rdy_q <= 1'b1;
    end else if (rx_ready_clear) begin
      rdy_q <= 1'b0;
    end
  end
  assign receive_data_ready_flag = rdy_q;

  // checker helper: cycles spent listening, kept apart from the window counter so a
  // broken window compare is still caught; saturates so it cannot wrap to zero
  always_ff @(posedge clk) begin
    if (rst || state_q != pfr_pkg::PFR_LISTEN) begin
      listen_age_q <= '0;
    end else if (listen_age_q != '1) begin
      listen_age_q <= listen_age_q + 17'd1;
    end
  end

  // checks
  chk_pipe_gate: assert property (@(posedge clk) disable iff (rst)
    pipe_dyn_len[0] |-> (global_dynamic_length_enable && auto_ack_pipe_enable[0]))
    else $error("pipe 0 dynamic length without enables");
  chk_pipe_high: assert property (@(posedge clk) disable iff (rst)
    pipe_dyn_len[5] |-> (global_dynamic_length_enable && dynamic_length_pipe_enables_q[5]))
    else $error("pipe 5 dynamic length without enables");
  chk_feat_write: assert property (@(posedge clk) disable iff (rst)
    reg_req.wr && reg_req.addr == pfr_pkg::FEATURE_OFFSET |=>
    global_dynamic_length_enable == $past(reg_req.wdata[2]))
    else $error("global dynamic length bit not stored");
  chk_ack_len: assert property (@(posedge clk) disable iff (rst)
    reg_req.wr && reg_req.addr == pfr_pkg::FEATURE_OFFSET |=>
    ack_dyn_len == $past(reg_req.wdata[1]))
    else $error("ack payload enable not applied");
  chk_noack_gate: assert property (@(posedge clk) disable iff (rst)
    noack_cmd_req && !feature_control_q[0] |-> !write_tx_payload_without_ack)
    else $error("no-ack command passed while disabled");
  chk_listen_leave: assert property (@(posedge clk) disable iff (rst)
    state_q == pfr_pkg::PFR_LISTEN |-> listen_age_q < lst_limit)
    else $error("listen window overran");
  chk_resend_expiry: assert property (@(posedge clk) disable iff (rst)
    resend |-> $past(rtx_expired) && state_q == pfr_pkg::PFR_TX)
    else $error("resend without delay expiry");
  chk_recv_stay: assert property (@(posedge clk) disable iff (rst)
    state_q == pfr_pkg::PFR_RECV && !rx_pkt_end && !rtx_expired |=>
    state_q == pfr_pkg::PFR_RECV)
    else $error("left receive before packet end");
  chk_ready_set: assert property (@(posedge clk) disable iff (rst)
    new_packet |=> receive_data_ready_flag)
    else $error("ready flag missed a packet");
  chk_ack_depth: assert property (@(posedge clk) disable iff (rst)
    ack_pay_full && ack_pay_push && !ack_pay_pop |=> ack_vld_q == 3'b111)
    else $error("ack queue overflow changed state");
endmodule

// ==== verification/pfr_radio_model.sv ====
// Purpose: radio core stand-in that plays one transmit and the reply heard after it
// Assumes: every event is a one cycle pulse, changed on the falling edge
// Notes: reply 0 is silence, 1 a good ack, 2 an address match that ends without ack
module pfr_radio_model (
  input wire logic clk,
  output logic tx_start,
  output logic tx_done,
  output logic addr_match,
  output logic rx_pkt_end,
  output logic ack_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // lines idle low between packets
  initial begin
    {tx_start, tx_done, addr_match, rx_pkt_end, ack_ok} = 5'h00;
  end
  // one packet on air, then the chosen reply well inside the listen window
  task automatic play(input int reply);
    @(negedge clk) tx_start = 1'b1;
    @(negedge clk) tx_start = 1'b0;
    repeat (3) @(negedge clk);
    tx_done = 1'b1;
    @(negedge clk) tx_done = 1'b0;
    if (reply != 0) begin
      // match comes early so the window cannot close first
      repeat (4) @(negedge clk);
      addr_match = 1'b1;
      @(negedge clk) addr_match = 1'b0;
      repeat (4) @(negedge clk);
      rx_pkt_end = 1'b1;
      ack_ok = (reply == 1);
      @(negedge clk) {rx_pkt_end, ack_ok} = 2'b00;
    end
  endtask
endmodule

// ==== verification/pfr_ctrl_tb.sv ====
// Purpose: self-checking bench for the packet feature and retransmit controller
// Assumes: short timing parameters stand in for the air counts
// Notes: inputs change on the falling edge only
module pfr_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LW = 20; // listen window, fast rates
  localparam int LS = 40; // listen window at 250k
  localparam int RS = 25; // one delay step
  logic clk = 1'b0;
  logic rst = 1'b1;
  pfr_pkg::pfr_reg_req_s reg_req = '0;
  logic [7:0] reg_rdata;
  logic [5:0] auto_ack_pipe_enable = 6'h00;
  logic [3:0] retransmit_delay = 4'h3; // 1 ms, at least 500 us on every rate
  pfr_pkg::pfr_rate_e air_rate = pfr_pkg::PFR_RATE_1M;
  logic noack_cmd_req = 1'b0;
  logic write_tx_payload_without_ack;
  logic ack_pay_push = 1'b0;
  pfr_pkg::pfr_ack_pay_s ack_pay_in = '0;
  logic ack_pay_full;
  logic ack_pay_pop = 1'b0;
  logic [2:0] ack_pay_pipe = 3'h0;
  logic ack_pay_hit;
  pfr_pkg::pfr_ack_pay_s ack_pay_out;
  logic ack_dyn_len;
  logic [5:0] pipe_dyn_len;
  logic tx_start, tx_done, addr_match, rx_pkt_end, ack_ok;
  pfr_pkg::pfr_state_e tx_state;
  logic resend;
  logic new_packet = 1'b0;
  logic rx_ready_clear = 1'b0;
  logic receive_data_ready_flag;
  int num_errors = 0;
  int checks_done = 0;
  logic [7:0] v;
  // 100 MHz clock
  always #5 clk = ~clk;
  pfr_ctrl #(.ADDR_WAIT_CYCLES(LW), .ADDR_WAIT_SLOW_CYCLES(LS), .RTX_STEP_CYCLES(RS)) dut_u (
    .clk, .rst, .reg_req, .reg_rdata, .auto_ack_pipe_enable, .retransmit_delay, .air_rate,
    .noack_cmd_req, .write_tx_payload_without_ack, .ack_pay_push, .ack_pay_in, .ack_pay_full,
    .ack_pay_pop, .ack_pay_pipe, .ack_pay_hit, .ack_pay_out, .ack_dyn_len, .pipe_dyn_len,
    .tx_start, .tx_done, .addr_match, .rx_pkt_end, .ack_ok, .tx_state, .resend,
    .new_packet, .rx_ready_clear, .receive_data_ready_flag);
  pfr_radio_model radio_u (.clk, .tx_start, .tx_done, .addr_match, .rx_pkt_end, .ack_ok);
  // compare and count
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // synchronous reset held n cycles; also reused mid run between scenarios
  task automatic do_reset(input int n);
    @(negedge clk) rst = 1'b1;
    repeat (n) @(negedge clk);
    rst = 1'b0;
  endtask
  // register port: one cycle strobes, read data valid the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk) reg_req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk) reg_req = '0;
    d = reg_rdata;
  endtask
  task automatic push(input logic [2:0] p, input logic [5:0] l);
    @(negedge clk) {ack_pay_push, ack_pay_in} = {1'b1, p, l};
    @(negedge clk) ack_pay_push = 1'b0;
  endtask
  task automatic pop();
    @(negedge clk) ack_pay_pop = 1'b1;
    @(negedge clk) ack_pay_pop = 1'b0;
  endtask
  task automatic t_regs();
    rd(pfr_pkg::FEATURE_OFFSET, v); chk("feature reset", v, 8'h00);
    rd(pfr_pkg::DYN_LEN_OFFSET, v); chk("dynlen reset", v, 8'h00);
    // reserved bits written as ones on purpose, to see them masked
    wr(pfr_pkg::FEATURE_OFFSET, 8'hff);
    rd(pfr_pkg::FEATURE_OFFSET, v); chk("feature mask", v, 8'h07);
    wr(pfr_pkg::DYN_LEN_OFFSET, 8'hff);
    rd(pfr_pkg::DYN_LEN_OFFSET, v); chk("dynlen mask", v, 8'h3f);
    rd(8'h1e, v); chk("unmapped", v, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_gate();
    auto_ack_pipe_enable = 6'h3f;
    wr(pfr_pkg::FEATURE_OFFSET, 8'h00);
    wr(pfr_pkg::DYN_LEN_OFFSET, 8'h3f);
    chk("no global", {2'b00, pipe_dyn_len}, 8'h00);
    wr(pfr_pkg::FEATURE_OFFSET, 8'h04);
    chk("all pipes", {2'b00, pipe_dyn_len}, 8'h3f);
    @(negedge clk) auto_ack_pipe_enable = 6'h2a;
    wr(pfr_pkg::DYN_LEN_OFFSET, 8'h0f);
    chk("auto ack gate", {2'b00, pipe_dyn_len}, 8'h0a);
    $display("test gate done");
  endtask
  task automatic t_noack();
    wr(pfr_pkg::FEATURE_OFFSET, 8'h00);
    @(negedge clk) noack_cmd_req = 1'b1;
    #1 chk("noack off", {7'h00, write_tx_payload_without_ack}, 8'h00);
    chk("ack var off", {7'h00, ack_dyn_len}, 8'h00);
    @(negedge clk) noack_cmd_req = 1'b0;
    wr(pfr_pkg::FEATURE_OFFSET, 8'h03);
    chk("ack var on", {7'h00, ack_dyn_len}, 8'h01);
    @(negedge clk) noack_cmd_req = 1'b1;
    #1 chk("noack on", {7'h00, write_tx_payload_without_ack}, 8'h01);
    @(negedge clk) noack_cmd_req = 1'b0;
    $display("test noack done");
  endtask
  // three pending, fourth dropped, pipes drain in their own order
  task automatic t_ackq();
    wr(pfr_pkg::FEATURE_OFFSET, 8'h06);
    wr(pfr_pkg::DYN_LEN_OFFSET, 8'h01); // sets pipe 0 enable bit only; pipe_dyn_len[0] stays low, auto-ack for pipe 0 is off
    push(3'h1, 6'h04);
    push(3'h2, 6'h07);
    push(3'h1, 6'h09);
    chk("full", {7'h00, ack_pay_full}, 8'h01);
    push(3'h2, 6'h01);
    ack_pay_pipe = 3'h1;
    #1 chk("pipe1 first", {ack_pay_hit, 1'b0, ack_pay_out.len}, 8'h84);
    pop();
    chk("pipe1 second", {ack_pay_hit, 1'b0, ack_pay_out.len}, 8'h89);
    pop();
    chk("not full", {7'h00, ack_pay_full}, 8'h00);
    ack_pay_pipe = 3'h2;
    #1 chk("pipe2 only", {ack_pay_hit, 1'b0, ack_pay_out.len}, 8'h87);
    pop();
    chk("drop lost", {7'h00, ack_pay_hit}, 8'h00);
    $display("test ackq done");
  endtask
  // host service: flag set by a new packet, then flag cleared
  task automatic t_flag();
    @(negedge clk) new_packet = 1'b1;
    @(negedge clk) new_packet = 1'b0;
    chk("flag set", {7'h00, receive_data_ready_flag}, 8'h01);
    rx_ready_clear = 1'b1;
    @(negedge clk) rx_ready_clear = 1'b0;
    chk("flag clr", {7'h00, receive_data_ready_flag}, 8'h00);
    @(negedge clk) {new_packet, rx_ready_clear} = 2'b11;
    @(negedge clk) {new_packet, rx_ready_clear} = 2'b00;
    chk("set wins", {7'h00, receive_data_ready_flag}, 8'h01);
    $display("test flag done");
  endtask
  // resend expected (code+1) steps after leaving transmit
  task automatic wait_resend(input int exp_n);
    int n;
    n = 0;
    while (n < 200 && resend !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    chk("resend time", 8'(n), 8'(exp_n));
  endtask
  task automatic t_silent(input pfr_pkg::pfr_rate_e r, input int win);
    do_reset(2);
    air_rate = r;
    radio_u.play(0);
    chk("listening", {5'h00, tx_state}, 8'h02);
    repeat (win - 3) @(negedge clk);
    chk("still listening", {5'h00, tx_state}, 8'h02);
    repeat (6) @(negedge clk);
    chk("window over", {5'h00, tx_state}, 8'h04);
    wait_resend(4 * RS - win - 3);
  endtask
  task automatic t_retx();
    t_silent(pfr_pkg::PFR_RATE_2M, LW);
    t_silent(pfr_pkg::PFR_RATE_250K, LS);
    do_reset(2);
    radio_u.play(1);
    chk("acked", {5'h00, tx_state}, 8'h00);
    radio_u.play(2);
    chk("no ack", {5'h00, tx_state}, 8'h04);
    wait_resend(4 * RS - 10);
    #1 chk("resent", {5'h00, tx_state}, 8'h01);
    $display("test retx done");
  endtask
  // watchdog: whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end
  initial begin
    do_reset(6);
    t_regs();
    t_gate();
    t_noack();
    t_ackq();
    t_flag();
    t_retx();
    final_report();
  end
endmodule
